// ===== core/pcpc_pkg.sv
// Constants shared by the pixel clock and phase comparator block.
// Operation
// - Three pixel clock inputs: fast external, oscillator input, internal I/O-derived 32MHz clock.
// - Control bits 0 and 1 select the pixel clock source.
// - Selected pixel clock passes a pre-scaler dividing by 1 to 8, bits 2 to 4.
// - Sound clock from internal 32MHz or 16MHz sound input, halved internally.
// - Two loadable down counters, reference and oscillator, feed a phase detector.
// - Software writes modulus minus one; counters reload with those values.
// - Bit 6 forces pump high, 7 clears reference counter, 14 forces low, 15 clears oscillator counter.
// - Pump output floats except while a correction is requested or bit 6 or 14 forces it; reset sets bit 14.
// - Pump drives high to raise oscillator frequency, low to lower it.
// - Locked oscillator frequency equals reference times v modulus over r modulus.
package pcpc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFFS_CTRL = 8'h00;
    localparam logic [7:0] OFFS_SYNTH = 8'h04;
    localparam logic [7:0] OFFS_STATUS = 8'h08;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_DIV_LSB = 2;
    localparam int CTRL_SOUND_BIT = 5;
    localparam int SYNTH_R_LSB = 0;
    localparam int SYNTH_FORCE_HI_BIT = 6;
    localparam int SYNTH_CLR_R_BIT = 7;
    localparam int SYNTH_V_LSB = 8;
    localparam int SYNTH_FORCE_LO_BIT = 14;
    localparam int SYNTH_CLR_V_BIT = 15;
    localparam int MOD_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] SYNTH_RESET = 16'hC080;
    localparam logic [1:0] SEL_IO32 = 2'h0;
    localparam logic [1:0] SEL_OSC = 2'h1;
    localparam logic [1:0] SEL_FAST = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {PUMP_IDLE, PUMP_UP, PUMP_DOWN} pcpc_pump_t;
endpackage

// ===== core/pcpc_top.sv
// Pixel and sound clock selection, pre-scaler and phase comparator with AXI4-Lite registers.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
module pcpc_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Asynchronous level in, filtered level and rising edge out
    input wire logic async,
    output logic stable,
    output logic rise
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic stable_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change is accepted only when the second and third stages agree.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            stable_reg <= 1'b0;
        else if (s2_reg == s3_reg)
            stable_reg <= s3_reg;
    end

    assign stable = stable_reg;
    assign rise = s2_reg & s3_reg & ~stable_reg;
endmodule

module pcpc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Clock pins
    input wire logic fastClockIn,
    input wire logic oscillator_clock_in,
    input wire logic io_clock_input,
    input wire logic soundClockIn,
    // Clock results
    output logic pixelClockTick,
    output logic soundClockOut,
    output logic oscillator_clock_inverted_out,
    // Pump pin, enable active low
    output logic phase_pump_output,
    output logic phasePumpOutEn_n
);
    logic fastRise;
    logic oscStable, oscRise;
    logic io_derived_32mhz_clock, ioRise;
    logic sndRise;

    // The internal 32MHz clock and the comparator reference are both the I/O clock input.
    pcpc_sync3 uFast (.clk(clk), .arst_n(arst_n), .async(fastClockIn), .stable(), .rise(fastRise));
    pcpc_sync3 uOsc (.clk(clk), .arst_n(arst_n), .async(oscillator_clock_in), .stable(oscStable), .rise(oscRise));
    pcpc_sync3 uIo (.clk(clk), .arst_n(arst_n), .async(io_clock_input), .stable(io_derived_32mhz_clock),
        .rise(ioRise));
    pcpc_sync3 uSnd (.clk(clk), .arst_n(arst_n), .async(soundClockIn), .stable(), .rise(sndRise));

    logic [5:0] ctrl_reg;
    logic [15:0] synth_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic doWrite;
    logic [31:0] readWord;
    logic [1:0] readResp;

    // Write address and data are taken independently; the response waits for both.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awready_reg <= 1'b1;
            awAddr_reg <= 8'h00;
        end
        else if (awvalid && awready_reg)
        begin
            awready_reg <= 1'b0;
            awAddr_reg <= awaddr;
        end
        else if (bvalid_reg && bready)
            awready_reg <= 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wready_reg <= 1'b1;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end
        else if (wvalid && wready_reg)
        begin
            wready_reg <= 1'b0;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
        end
        else if (bvalid_reg && bready)
            wready_reg <= 1'b1;
    end

    assign doWrite = !awready_reg && !wready_reg && !bvalid_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= pcpc_pkg::RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (awAddr_reg == pcpc_pkg::OFFS_CTRL || awAddr_reg == pcpc_pkg::OFFS_SYNTH)
                ? pcpc_pkg::RESP_OKAY : pcpc_pkg::RESP_SLVERR;
        end
        else if (bvalid_reg && bready)
            bvalid_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_reg <= pcpc_pkg::CTRL_RESET;
        else if (doWrite && awAddr_reg == pcpc_pkg::OFFS_CTRL && wStrb_reg[0])
            ctrl_reg <= wData_reg[5:0];
    end

    // Software loads modulus minus one; the counters reload from these fields.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            synth_reg <= pcpc_pkg::SYNTH_RESET;
        else if (doWrite && awAddr_reg == pcpc_pkg::OFFS_SYNTH)
        begin
            if (wStrb_reg[0])
                synth_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1])
                synth_reg[15:8] <= wData_reg[15:8];
        end
    end

    logic [5:0] refCnt_reg, vcoCnt_reg;
    pcpc_pkg::pcpc_pump_t pumpState_reg;

    always_comb
    begin
        readWord = 32'h0000_0000;
        readResp = pcpc_pkg::RESP_OKAY;
        if (araddr == pcpc_pkg::OFFS_CTRL)
            readWord = {26'h000_0000, ctrl_reg};
        else if (araddr == pcpc_pkg::OFFS_SYNTH)
            readWord = 32'h0000_0000;
        else if (araddr == pcpc_pkg::OFFS_STATUS)
            readWord = {16'h0000, 2'h0, pumpState_reg, vcoCnt_reg, refCnt_reg};
        else
            readResp = pcpc_pkg::RESP_SLVERR;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= pcpc_pkg::RESP_OKAY;
        end
        else if (arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= readWord;
            rresp_reg <= readResp;
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Pixel source select and pre-scaler.
    logic pixRise;
    logic [2:0] divCnt_reg;
    logic pixTick_reg;
    logic [2:0] divField;
    assign divField = ctrl_reg[pcpc_pkg::CTRL_DIV_LSB +: 3];

    always_comb
    begin
        unique case (ctrl_reg[pcpc_pkg::CTRL_SEL_LSB +: 2])
            pcpc_pkg::SEL_IO32: pixRise = ioRise;
            pcpc_pkg::SEL_OSC: pixRise = oscRise;
            pcpc_pkg::SEL_FAST: pixRise = fastRise;
            default: pixRise = 1'b0;
        endcase
    end

    // Field value n gives one tick every n plus one source edges.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCnt_reg <= 3'h0;
            pixTick_reg <= 1'b0;
        end
        else
        begin
            pixTick_reg <= pixRise && divCnt_reg >= divField;
            if (pixRise)
                divCnt_reg <= (divCnt_reg >= divField) ? 3'h0 : divCnt_reg + 3'h1;
        end
    end

    // Sound clock toggles on each chosen edge, halving the source.
    logic soundClk_reg;
    logic sndSrcRise;
    assign sndSrcRise = ctrl_reg[pcpc_pkg::CTRL_SOUND_BIT] ? sndRise : ioRise;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            soundClk_reg <= 1'b0;
        else if (sndSrcRise)
            soundClk_reg <= ~soundClk_reg;
    end

    logic oscInv_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            oscInv_reg <= 1'b1;
        else
            oscInv_reg <= ~oscStable;
    end

    // Reference and oscillator down counters.
    logic [5:0] rMod, vMod;
    logic refClear, vcoClear, refTerm, vcoTerm;
    assign rMod = synth_reg[pcpc_pkg::SYNTH_R_LSB +: pcpc_pkg::MOD_W];
    assign vMod = synth_reg[pcpc_pkg::SYNTH_V_LSB +: pcpc_pkg::MOD_W];
    assign refClear = synth_reg[pcpc_pkg::SYNTH_CLR_R_BIT];
    assign vcoClear = synth_reg[pcpc_pkg::SYNTH_CLR_V_BIT];
    assign refTerm = ioRise && !refClear && refCnt_reg == 6'h00;
    assign vcoTerm = oscRise && !vcoClear && vcoCnt_reg == 6'h00;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            refCnt_reg <= 6'h00;
        else if (refClear)
            refCnt_reg <= 6'h00;
        else if (ioRise)
            refCnt_reg <= refTerm ? rMod : refCnt_reg - 6'h01;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            vcoCnt_reg <= 6'h00;
        else if (vcoClear)
            vcoCnt_reg <= 6'h00;
        else if (oscRise)
            vcoCnt_reg <= vcoTerm ? vMod : vcoCnt_reg - 6'h01;
    end

    // Phase detector: whichever terminal count comes first opens a correction the other closes.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pumpState_reg <= pcpc_pkg::PUMP_IDLE;
        else if (refTerm && vcoTerm)
            pumpState_reg <= pcpc_pkg::PUMP_IDLE;
        else if (refTerm)
            pumpState_reg <= (pumpState_reg == pcpc_pkg::PUMP_DOWN) ? pcpc_pkg::PUMP_IDLE : pcpc_pkg::PUMP_UP;
        else if (vcoTerm)
            pumpState_reg <= (pumpState_reg == pcpc_pkg::PUMP_UP) ? pcpc_pkg::PUMP_IDLE : pcpc_pkg::PUMP_DOWN;
    end

    // Forcing low wins over forcing high, since a runaway oscillator cannot recover.
    logic pump_reg, pumpEn_n_reg;
    logic forceHi, forceLo;
    assign forceHi = synth_reg[pcpc_pkg::SYNTH_FORCE_HI_BIT];
    assign forceLo = synth_reg[pcpc_pkg::SYNTH_FORCE_LO_BIT];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pump_reg <= 1'b0;
            pumpEn_n_reg <= 1'b1;
        end
        else if (forceLo)
        begin
            pump_reg <= 1'b0;
            pumpEn_n_reg <= 1'b0;
        end
        else if (forceHi)
        begin
            pump_reg <= 1'b1;
            pumpEn_n_reg <= 1'b0;
        end
        else
        begin
            pump_reg <= (pumpState_reg == pcpc_pkg::PUMP_UP);
            pumpEn_n_reg <= (pumpState_reg == pcpc_pkg::PUMP_IDLE);
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign pixelClockTick = pixTick_reg;
    assign soundClockOut = soundClk_reg;
    assign oscillator_clock_inverted_out = oscInv_reg;
    assign phase_pump_output = pump_reg;
    assign phasePumpOutEn_n = pumpEn_n_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_forceLow;
        forceLo |=> !phase_pump_output && !phasePumpOutEn_n;
    endproperty
    a_forceLow: assert property (p_forceLow) else $error("Pump not forced low.");

    property p_forceHigh;
        forceHi && !forceLo |=> phase_pump_output && !phasePumpOutEn_n;
    endproperty
    a_forceHigh: assert property (p_forceHigh) else $error("Pump not forced high.");

    property p_refClear;
        refClear |-> !refTerm ##1 refCnt_reg == 6'h00;
    endproperty
    a_refClear: assert property (p_refClear) else $error("Reference counter not cleared.");

    property p_vcoClear;
        vcoClear |=> vcoCnt_reg == 6'h00;
    endproperty
    a_vcoClear: assert property (p_vcoClear) else $error("Oscillator counter not cleared.");

    property p_reload;
        refTerm |=> refCnt_reg == $past(rMod);
    endproperty
    a_reload: assert property (p_reload) else $error("Reference counter did not reload.");

    property p_float;
        pumpState_reg == pcpc_pkg::PUMP_IDLE && !forceHi && !forceLo |=> phasePumpOutEn_n;
    endproperty
    a_float: assert property (p_float) else $error("Pump driven while idle.");

    property p_upHigh;
        pumpState_reg == pcpc_pkg::PUMP_UP && !forceHi && !forceLo |=> phase_pump_output && !phasePumpOutEn_n;
    endproperty
    a_upHigh: assert property (p_upHigh) else $error("Pump not high while raising.");

    property p_refFirst;
        pumpState_reg == pcpc_pkg::PUMP_IDLE && refTerm && !vcoTerm ##1 !forceHi && !forceLo
            |=> phase_pump_output && !phasePumpOutEn_n;
    endproperty
    a_refFirst: assert property (p_refFirst) else $error("Reference first did not drive high.");

    property p_divTick;
        pixRise && divCnt_reg >= divField |=> pixelClockTick ##1 !pixelClockTick;
    endproperty
    a_divTick: assert property (p_divTick) else $error("Pre-scaler tick missing.");

    property p_sound;
        sndSrcRise |=> soundClockOut != $past(soundClockOut);
    endproperty
    a_sound: assert property (p_sound) else $error("Sound clock did not toggle.");

    c_pumpUp: cover property (pumpState_reg == pcpc_pkg::PUMP_UP ##1 !phasePumpOutEn_n);
    c_pumpDown: cover property (pumpState_reg == pcpc_pkg::PUMP_DOWN && !forceLo);
    c_divEight: cover property (pixelClockTick && divField == 3'h7);
    c_write: cover property (bvalid && bready && bresp == pcpc_pkg::RESP_OKAY);
endmodule

// ===== testbench/pcpc_vco_model.sv
// Behavioural oscillator and loop filter that sit on the pump pin.
module pcpc_vco_model (
    // Clock
    input wire logic clk,
    // Pump line and stop control
    input wire logic pumpLine,
    input wire logic hold,
    // Oscillator output
    output logic oscOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int level = 0;
    int phase = 0;
    int kick;
    initial oscOut = 1'b0;
    // The kick term is the filter zero; a bare integrator would only ever ring.
    always_comb kick = pumpLine === 1'b1 ? 1 : (pumpLine === 1'b0 ? -1 : 0);
    always @(posedge clk)
    begin
        if (pumpLine === 1'b1 && level < 90)
            level <= level + 1;
        else if (pumpLine === 1'b0 && level > 0)
            level <= level - 1;
        if (hold)
            oscOut <= 1'b0;
        if (hold || phase >= 12 - level / 10 - kick)
            phase <= 0;
        else
            phase <= phase + 1;
        if (!hold && phase >= 12 - level / 10 - kick)
            oscOut <= !oscOut;
    end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the pixel clock and phase comparator block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic fastClockIn = 1'b0;
    logic io_clock_input = 1'b0;
    logic soundClockIn = 1'b0;
    logic ioRun = 1'b1;
    logic ioMan = 1'b0;
    logic oscHold = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic oscillator_clock_in, pixelClockTick, soundClockOut;
    logic oscillator_clock_inverted_out, phase_pump_output, phasePumpOutEn_n;
    logic [4:0] pinPrev = 5'h00;
    logic [4:0] oscHist = 5'h00;
    wire logic [4:0] pins = {soundClockOut, soundClockIn, fastClockIn, oscillator_clock_in, io_clock_input};
    wire logic pumpLine = phasePumpOutEn_n ? 1'bz : phase_pump_output;
    int err_total = 0;
    int cmp_count = 0;
    int cnt = 0;
    int tickCount = 0;
    int rise[5] = '{default: 0};

    pcpc_top dut_u (.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .fastClockIn, .oscillator_clock_in, .io_clock_input, .soundClockIn, .pixelClockTick,
        .soundClockOut, .oscillator_clock_inverted_out, .phase_pump_output, .phasePumpOutEn_n);
    pcpc_vco_model vco_u (.clk, .pumpLine, .hold(oscHold), .oscOut(oscillator_clock_in));

    initial forever #5 clk = ~clk;

    // Pin clocks are slow on purpose: the pin synchronisers need two cycles per level.
    always @(posedge clk)
    begin
        cnt <= cnt + 1;
        fastClockIn <= cnt % 10 < 5;
        soundClockIn <= cnt % 12 < 6;
        io_clock_input <= ioRun ? cnt % 8 < 4 : ioMan;
        pinPrev <= pins;
        oscHist <= {oscHist[3:0], oscillator_clock_in};
        tickCount <= tickCount + (pixelClockTick === 1'b1);
        for (int j = 0; j < 5; j++)
            if (pins[j] !== pinPrev[j] && (j == 4 || pins[j] === 1'b1))
                rise[j] <= rise[j] + 1;
    end

    task automatic finish_test();
        $display("Counts: %0d mismatches, %0d comparisons", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic timeout(input string msg);
        err_total++;
        $display("wrong value at %0t: %s timed out", $time, msg);
        finish_test();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol, input string msg);
        cmp_count++;
        if (got > exp + tol || got < exp - tol)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = pcpc_pkg::RESP_OKAY, input logic [3:0] s = 4'hF);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50 && bvalid !== 1'b1; i++)
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        if (i == 50) timeout("write");
        bready <= 1'b0;
        check(32'(bresp), 32'(er), "write response");
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er = pcpc_pkg::RESP_OKAY);
        int i;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50 && rvalid !== 1'b1; i++)
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (i == 50) timeout("read");
        rd = rdata;
        rready <= 1'b0;
        check(32'(rresp), 32'(er), "read response");
    endtask

    task automatic synth(input logic [31:0] d);
        axi_write(pcpc_pkg::OFFS_SYNTH, d);
    endtask

    task automatic wait_pump(input logic en, input logic val, input string msg);
        int i;
        for (i = 0; i < 300 && !(phasePumpOutEn_n === en && (en || phase_pump_output === val)); i++)
            @(posedge clk);
        if (i == 300) timeout(msg);
        check(32'(phasePumpOutEn_n), 32'(en), msg);
    endtask

    task automatic io_pulse();
        ioMan <= 1'b1;
        repeat (3) @(posedge clk);
        ioMan <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic test_regs();
        axi_read(pcpc_pkg::OFFS_CTRL);
        check(rd, 32'h00000000, "control reset");
        axi_write(pcpc_pkg::OFFS_CTRL, 32'h0000003F);
        axi_write(pcpc_pkg::OFFS_CTRL, 32'h00000000, pcpc_pkg::RESP_OKAY, 4'h0);
        axi_read(pcpc_pkg::OFFS_CTRL);
        check(rd, 32'h0000003F, "control lanes");
        axi_read(pcpc_pkg::OFFS_SYNTH);
        check(rd, 32'h00000000, "synth write only");
        axi_write(pcpc_pkg::OFFS_STATUS, 32'h00000000, pcpc_pkg::RESP_SLVERR);
        axi_write(8'h0C, 32'h00000000, pcpc_pkg::RESP_SLVERR);
        axi_read(8'h0C, pcpc_pkg::RESP_SLVERR);
        check(rd, 32'h00000000, "unmapped read");
        $display("test regs done");
    endtask

    task automatic test_forces();
        synth(32'h0000C183);
        wait_pump(1'b0, 1'b0, "start-up low");
        axi_read(pcpc_pkg::OFFS_STATUS);
        check(rd & 32'h00000FFF, 32'h00000000, "counters cleared");
        synth(32'h000080C3);
        wait_pump(1'b0, 1'b1, "forced high");
        synth(32'h0000C0C3);
        wait_pump(1'b0, 1'b0, "low wins");
        $display("test forces done");
    endtask

    task automatic test_modulus();
        ioRun <= 1'b0;
        repeat (8) @(posedge clk);
        synth(32'h00008003);
        repeat (5) io_pulse();
        repeat (8) @(posedge clk);
        axi_read(pcpc_pkg::OFFS_STATUS);
        check(rd & 32'h0000003F, 32'h00000003, "reference reload");
        repeat (2) io_pulse();
        repeat (8) @(posedge clk);
        axi_read(pcpc_pkg::OFFS_STATUS);
        check(rd & 32'h0000003F, 32'h00000001, "reference count");
        wait_pump(1'b0, 1'b1, "reference alone");
        $display("test modulus done");
    endtask

    task automatic test_phase();
        synth(32'h0000C181);
        oscHold <= 1'b1;
        ioRun <= 1'b1;
        synth(32'h00000101);
        wait_pump(1'b0, 1'b1, "reference leads");
        ioRun <= 1'b0;
        oscHold <= 1'b0;
        wait_pump(1'b1, 1'b0, "float after oscillator");
        wait_pump(1'b0, 1'b0, "oscillator leads");
        oscHold <= 1'b1;
        ioRun <= 1'b1;
        wait_pump(1'b1, 1'b0, "float after reference");
        $display("test phase done");
    endtask

    task automatic test_pixel();
        int b[5];
        int t, n, sel, src;
        oscHold <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            n = k % 8;
            sel = k < 8 ? (k + 1) % 3 : 3;
            src = k % 2 ? 3 : 0;
            axi_write(pcpc_pkg::OFFS_CTRL, 32'(k % 2 * 32 + n * 4 + sel));
            repeat (20) @(posedge clk);
            b = rise;
            t = tickCount;
            repeat (1000) @(posedge clk);
            near(tickCount - t, sel == 3 ? 0 : (rise[sel] - b[sel]) / (n + 1), 1, "pixel ticks");
            near(rise[4] - b[4], rise[src] - b[src], 1, "sound toggles");
            check(32'(oscillator_clock_inverted_out), 32'(!oscHist[4]), "oscillator inverse");
        end
        $display("test pixel done");
    endtask

    task automatic test_lock();
        int b[5];
        synth(32'h00000103);
        repeat (4000) @(posedge clk);
        b = rise;
        repeat (4000) @(posedge clk);
        near(rise[1] - b[1], (rise[0] - b[0]) * 2 / 4, 40, "locked rate");
        $display("test lock done");
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(32'(phasePumpOutEn_n), 32'h0, "reset drive");
        check(32'(phase_pump_output), 32'h0, "reset level");
        test_regs();
        test_forces();
        test_modulus();
        test_phase();
        test_pixel();
        test_lock();
        finish_test();
    end
endmodule
